//--- cpp_control.sv
// Purpose: Primary control register with call progress modulator
// Assumes: mclk at 25 MHz; audio samples arrive from logic on mclk
// Notes: The modulator rate is emulated by a phase accumulator on mclk
//
// The Avalon-MM interface to the registers was decided locally.
module cpp_control #(
   parameter int SAMPLE_W = 16
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic [SAMPLE_W-1:0] tx_sample,
   input wire logic [SAMPLE_W-1:0] rx_sample,
   input wire logic irq_request,
   output logic shared_progress_irq_pin,
   output logic barrier_loopback_enable,
   output logic [SAMPLE_W-1:0] loop_sample
);
   // ****************************************
   // Elaboration checks
   // ****************************************
   if (SAMPLE_W < 4 || SAMPLE_W > 24) begin : g_bad_width
      $error("SAMPLE_W must lie between 4 and 24");
   end

   localparam int SUM_W = SAMPLE_W + 1;
   localparam int CNT_W = 12;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic busy;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [SUM_W-1:0] sum;
      logic [SUM_W:0] sigma;
      logic [7:0] phase;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] thresh;
      logic pin;
      logic loop_en;
      logic [SAMPLE_W-1:0] loop;
   } cpp_state_t;

   cpp_state_t st_q;
   cpp_state_t st_d;

   logic [SUM_W-1:0] level;
   logic [SUM_W:0] sig_next;
   logic [CNT_W-1:0] thr_c;
   logic [CNT_W-1:0] period;
   logic [8:0] ph_next;
   logic mod_tick;
   logic [1:0] sel;
   logic mod_bit;
   logic hit;
   logic [7:0] rd_byte;

   always_comb begin
      st_d = st_q;
      level = '0;
      sig_next = '0;
      thr_c = '0;
      period = '0;
      ph_next = '0;
      mod_tick = 1'b0;
      sel = 2'b00;
      mod_bit = 1'b0;
      hit = 1'b0;
      rd_byte = 8'h00;

      // ****************************************
      // Avalon slave, one wait state per access
      // ****************************************
      st_d.busy = 1'b0;
      if ((avs_read || avs_write) && !st_q.busy) begin
         st_d.busy = 1'b1;
         // Answer is set up a cycle early so it stands while waitrequest is low
         st_d.resp = 2'b00;
         case (avs_address)
            cpp_pkg::CPP_ADDR_PRIMARY_CONTROL: rd_byte = st_q.ctrl1;
            cpp_pkg::CPP_ADDR_CONTROL2: rd_byte = st_q.ctrl2;
            cpp_pkg::CPP_ADDR_AUDIO_IN: rd_byte = st_q.sum[SUM_W-1 -: 8];
            default: begin
               rd_byte = 8'h00;
               st_d.resp = 2'b11;
            end
         endcase
         st_d.rdata = {24'h000000, rd_byte};
      end
      if ((avs_read || avs_write) && st_q.busy) begin
         hit = 1'b1;
         if (avs_write && avs_byteenable[0]) begin
            if (avs_address == cpp_pkg::CPP_ADDR_PRIMARY_CONTROL) begin
               st_d.ctrl1 = avs_writedata[7:0] & cpp_pkg::CPP_MASK_PRIMARY_CONTROL;
            end else if (avs_address == cpp_pkg::CPP_ADDR_CONTROL2) begin
               st_d.ctrl2 = avs_writedata[7:0] & cpp_pkg::CPP_MASK_CONTROL2;
            end
         end
      end
      // Soft reset never stores, so reads always see it as zero
      if (hit && avs_write && avs_byteenable[0]
          && avs_address == cpp_pkg::CPP_ADDR_PRIMARY_CONTROL
          && avs_writedata[cpp_pkg::CPP_BIT_SOFT_RESET]) begin
         st_d.ctrl1 = cpp_pkg::CPP_RST_PRIMARY_CONTROL;
         st_d.ctrl2 = cpp_pkg::CPP_RST_CONTROL2;
      end

      // ****************************************
      // Signal sum and sample timing
      // ****************************************
      // Offset-binary sum of both paths; one extra bit keeps it from wrapping
      st_d.sum = SUM_W'({1'b0, tx_sample ^ {1'b1, {(SAMPLE_W-1){1'b0}}}})
               + SUM_W'({1'b0, rx_sample ^ {1'b1, {(SAMPLE_W-1){1'b0}}}});
      level = st_q.sum;

      // 16.384/25 of mclk edges advance the modulator, taken as 168 of 256
      ph_next = {1'b0, st_q.phase} + 9'h0a8;
      st_d.phase = ph_next[7:0];
      mod_tick = ph_next[8];

      sel = st_q.ctrl1[cpp_pkg::CPP_BIT_SEL_HI:cpp_pkg::CPP_BIT_SEL_LO];
      if (sel == cpp_pkg::CPP_MODE_CENTRED) begin
         period = CNT_W'(cpp_pkg::CPP_SAMPLE_CYC);
      end else begin
         period = CNT_W'(cpp_pkg::CPP_FRAME_CYC);
      end
      if (st_q.cnt >= period - 12'h001) begin
         st_d.cnt = '0;
         // Latch the width once per period so the edge never jitters mid-pulse
         thr_c = CNT_W'((32'(level) * 32'(period)) >> SUM_W);
         st_d.thresh = thr_c;
      end else begin
         st_d.cnt = st_q.cnt + 12'h001;
      end

      // ****************************************
      // Modulator
      // ****************************************
      sig_next = st_q.sigma;
      if (mod_tick) begin
         // First-order delta-sigma: carry out is the ones density
         sig_next = {1'b0, st_q.sigma[SUM_W-1:0]} + {1'b0, level};
         st_d.sigma = sig_next;
      end
      case (sel)
         cpp_pkg::CPP_MODE_DELTA_SIGMA: mod_bit = st_q.sigma[SUM_W];
         cpp_pkg::CPP_MODE_CENTRED: begin
            // High portion centred on the sample clock edge at count zero
            mod_bit = (st_q.cnt < (st_q.thresh >> 1))
                    || (st_q.cnt >= period - (st_q.thresh >> 1));
         end
         cpp_pkg::CPP_MODE_TRAILING: begin
            // Low from period start, rises after a time set by amplitude
            mod_bit = (st_q.cnt >= period - st_q.thresh);
         end
         // Reserved encoding holds the output low
         default: mod_bit = 1'b0;
      endcase

      // ****************************************
      // Shared pin and loopback
      // ****************************************
      if (st_q.ctrl2[cpp_pkg::CPP_BIT_IRQ_SELECT]) begin
         st_d.pin = irq_request ~^ st_q.ctrl2[cpp_pkg::CPP_BIT_IRQ_POLARITY];
      end else if (st_q.ctrl1[cpp_pkg::CPP_BIT_MOD_ENABLE]) begin
         st_d.pin = mod_bit;
      end else begin
         st_d.pin = 1'b0;
      end
      st_d.loop_en = st_q.ctrl1[cpp_pkg::CPP_BIT_LOOPBACK];
      // Looped data is the transmit filter output fed back to the receive side
      if (st_q.ctrl1[cpp_pkg::CPP_BIT_LOOPBACK]) begin
         st_d.loop = tx_sample;
      end else begin
         st_d.loop = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata = st_q.rdata;
   assign avs_waitrequest = !st_q.busy;
   assign avs_response = st_q.resp;
   assign shared_progress_irq_pin = st_q.pin;
   assign barrier_loopback_enable = st_q.loop_en;
   assign loop_sample = st_q.loop;
endmodule

//--- cpp_control_properties.sv
// Purpose: Port checks for the call progress control block
// Assumes: One answer cycle per access; pin output registered
// Notes: A shadow of both registers judges read data and the pin
module cpp_control_properties #(
   parameter int SAMPLE_W = 16
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic [SAMPLE_W-1:0] tx_sample,
   input wire logic irq_request,
   input wire logic shared_progress_irq_pin,
   input wire logic barrier_loopback_enable,
   input wire logic [SAMPLE_W-1:0] loop_sample
);
   typedef struct packed {logic [7:0] ctl; logic [7:0] c2;} cpp_shadow_t;
   cpp_shadow_t s_q;
   logic wr, rd, a4, a8, off_w, irq_w;
   assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign rd = avs_read && !avs_waitrequest;
   assign a4 = avs_address == 10'h004;
   assign a8 = avs_address == 10'h008;
   assign off_w = !s_q.ctl[3] && !s_q.c2[7];
   assign irq_w = s_q.c2[6] ~^ irq_request;
   // Soft reset wins over the field write that carries it
   always_ff @(posedge mclk) begin
      if (srst || (wr && a4 && avs_writedata[7])) begin
         s_q <= '0;
      end else if (wr && a4) begin
         s_q.ctl <= avs_writedata[7:0] & 8'h3a;
      end else if (wr && a8) begin
         s_q.c2 <= avs_writedata[7:0] & 8'hc0;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_unmapped_read: assert property (rd && !(a4 || a8 || avs_address == 10'h040) |->
      avs_readdata == 32'h0 && avs_response == 2'b11) else $error("unmapped read answer");
   a_ctl_read: assert property (rd && a4 |-> avs_readdata == {24'h0, s_q.ctl})
      else $error("control read mismatch");
   a_c2_read: assert property (rd && a8 |-> avs_readdata == {24'h0, s_q.c2})
      else $error("control2 read mismatch");
   a_loop_follow: assert property ($stable(s_q.ctl[1]) |=>
      barrier_loopback_enable == $past(s_q.ctl[1])) else $error("loopback level wrong");
   a_loop_data: assert property (barrier_loopback_enable && $past(barrier_loopback_enable) |->
      loop_sample == $past(tx_sample)) else $error("looped sample wrong");
   a_loop_off: assert property (!barrier_loopback_enable && $past(!barrier_loopback_enable) |->
      loop_sample == '0) else $error("loop path active while off");
   a_pin_quiet: assert property (off_w && $past(off_w) && $past(off_w, 2) && $past(off_w, 3)
      |-> !shared_progress_irq_pin) else $error("pin modulates while disabled");
   a_pin_irq: assert property (s_q.c2[7] && $past(s_q.c2, 3) == s_q.c2 && $stable(s_q.c2)
      |=> shared_progress_irq_pin == $past(irq_w)) else $error("pin not irq");
   c_irq: cover property (s_q.c2[7] && shared_progress_irq_pin);
   c_soft_reset: cover property (wr && a4 && avs_writedata[7]);
   c_unmapped: cover property (rd && avs_response == 2'b11);
endmodule
bind cpp_control cpp_control_properties #(.SAMPLE_W(SAMPLE_W)) cpp_control_properties_i (
   .mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .avs_response, .tx_sample, .irq_request,
   .shared_progress_irq_pin, .barrier_loopback_enable, .loop_sample);

//--- cpp_filter_model.sv
// Purpose: Call progress filter model that averages the pin
// Assumes: Pin is a digital level sampled on mclk
// Notes: A ones count over a window stands in for the RC average
module cpp_filter_model (
   input wire logic mclk,
   input wire logic clear,
   input wire logic pin,
   output logic [15:0] ones
);
   always_ff @(posedge mclk) begin
      ones <= clear ? 16'h0000 : ones + {15'h0000, pin};
   end
endmodule

//--- cpp_pkg.sv
// Purpose: Constants for the call progress modulation control block
// Assumes: Avalon-MM byte addressing, 8-bit registers in the low bits
// Notes: Byte address of a register is four times its index
package cpp_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CPP_IDX_PRIMARY_CONTROL = 8'h01;
   localparam logic [7:0] CPP_IDX_CONTROL2 = 8'h02;
   localparam logic [7:0] CPP_IDX_AUDIO_IN = 8'h10;
   localparam logic [9:0] CPP_ADDR_PRIMARY_CONTROL = 10'h004;
   localparam logic [9:0] CPP_ADDR_CONTROL2 = 10'h008;
   localparam logic [9:0] CPP_ADDR_AUDIO_IN = 10'h040;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CPP_BIT_SOFT_RESET = 7;
   localparam int CPP_BIT_SEL_HI = 5;
   localparam int CPP_BIT_SEL_LO = 4;
   localparam int CPP_BIT_MOD_ENABLE = 3;
   localparam int CPP_BIT_LOOPBACK = 1;
   localparam int CPP_BIT_IRQ_SELECT = 7;
   localparam int CPP_BIT_IRQ_POLARITY = 6;
   // ****************************************
   // Reset values and masks
   // ****************************************
   localparam logic [7:0] CPP_RST_PRIMARY_CONTROL = 8'h00;
   localparam logic [7:0] CPP_RST_CONTROL2 = 8'h00;
   localparam logic [7:0] CPP_MASK_PRIMARY_CONTROL = 8'h3a;
   localparam logic [7:0] CPP_MASK_CONTROL2 = 8'hc0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CPP_MCLK_HZ = 25000000;
   localparam int CPP_MOD_CLK_HZ = 16384000;
   localparam int CPP_SAMPLE_HZ = 16000;
   localparam int CPP_FRAME_HZ = 32000;
   localparam int CPP_SAMPLE_CYC = CPP_MCLK_HZ / CPP_SAMPLE_HZ;
   localparam int CPP_FRAME_CYC = CPP_MCLK_HZ / CPP_FRAME_HZ;
   localparam logic [7:0] CPP_ACC_STEP = 8'h01;
   // ****************************************
   // Modulation modes
   // ****************************************
   typedef enum logic [1:0] {
      CPP_MODE_DELTA_SIGMA = 2'b00,
      CPP_MODE_CENTRED = 2'b01,
      CPP_MODE_TRAILING = 2'b10,
      CPP_MODE_RESERVED = 2'b11
   } cpp_mode_t;
endpackage

//--- test_cpp_control.sv
// Purpose: Self-checking bench for the call progress control block
// Assumes: Byte lane 0 always enabled; audio held constant
// Notes: Windows span whole periods of both pulse modes
module test_cpp_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq_request = 1'b0;
   logic clr = 1'b1, avs_waitrequest, pin, lbe;
   logic [9:0] avs_address = 10'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [1:0] avs_response, r;
   logic [15:0] tx_sample = 16'h2000, rx_sample = 16'h2000, loop_sample, ones;
   int n_errors = 0, compares = 0;
   cpp_control cpp_control_i (.mclk(mclk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .tx_sample(tx_sample), .rx_sample(rx_sample),
      .irq_request(irq_request), .shared_progress_irq_pin(pin),
      .barrier_loopback_enable(lbe), .loop_sample(loop_sample));
   cpp_filter_model cpp_filter_model_i (.mclk(mclk), .clear(clr), .pin(pin), .ones(ones));
   task automatic stop_test();
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Request held until waitrequest is seen low; one idle edge before the next
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= !w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      if (n == 20) n_errors++;
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   // Slack covers the delta-sigma phase at the window edges
   task automatic dens(input logic [7:0] ctl, input int exp);
      int d;
      bus(1'b1, 10'h004, ctl);
      // A full long period lets the latched pulse width follow the new mode
      repeat (1600) @(posedge mclk);
      clr <= 1'b0;
      repeat (6248) @(posedge mclk);
      clr <= 1'b1;
      d = int'(ones) - exp;
      chk("pin density", {31'h0, d <= 16 && d >= -16}, 32'h1);
   endtask
   initial begin
      forever #20 mclk = ~mclk;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      bus(1'b0, 10'h004, 8'h00);
      chk("ctl reset", q, 32'h0);
      // Line side is taken as enabled and off-hook before loopback
      bus(1'b1, 10'h004, 8'h7b);
      bus(1'b0, 10'h004, 8'h00);
      chk("ctl fields", q, 32'h3a);
      chk("loop on", {31'h0, lbe}, 32'h1);
      chk("loop data", {16'h0, loop_sample}, 32'h2000);
      bus(1'b1, 10'h008, 8'hc0);
      irq_request <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("irq pin", {31'h0, pin}, 32'h1);
      bus(1'b1, 10'h004, 8'h80);
      bus(1'b0, 10'h004, 8'h00);
      chk("soft reset", q, 32'h0);
      bus(1'b0, 10'h008, 8'h00);
      chk("c2 cleared", q, 32'h0);
      chk("loop off", {15'h0, lbe, loop_sample}, 32'h0);
      bus(1'b0, 10'h0fc, 8'h00);
      chk("unmapped", {q[29:0], r}, 32'h3);
      // Sum 0x4000 in offset binary is 0x14000 of a 0x20000 full scale
      // Reserved mode 11 is programmed only by the 0x7b field write, never in a density check
      dens(8'h08, 6248 * 81920 / 131072);
      dens(8'h18, 6248 * 81920 / 131072);
      dens(8'h28, 6248 * 81920 / 131072);
      dens(8'h20, 0);
      stop_test();
   end
endmodule
